//--- logic/rx_seg_pkg.sv
/*
  Shared constants of the segmented receive output path: segment count and widths,
  the layout of one segment inside a buffered word, reset timing and buffer depth.
  Assumes a single 250 MHz clock on the user side of the receive path.
*/
package rx_seg_pkg;
  // segment geometry
  localparam int SEG_COUNT = 4;
  localparam int SEG_DATA_W = 128;
  localparam int SEG_EMPTY_W = 4;

  // layout of one segment slice inside a buffered word
  localparam int SEG_DATA_LSB = 0;
  localparam int SEG_EMPTY_LSB = 128;
  localparam int SEG_VALID_BIT = 132;
  localparam int SEG_FIRST_BIT = 133;
  localparam int SEG_LAST_BIT = 134;
  localparam int SEG_BAD_BIT = 135;
  localparam int SEG_W = 136;
  localparam int WORD_W = SEG_COUNT * SEG_W;

  // empty count bits kept on an errored segment: only the top bit survives
  localparam logic [SEG_EMPTY_W-1:0] EMPTY_BAD_KEEP = 4'h8;
  localparam logic [SEG_EMPTY_W-1:0] EMPTY_RESET = 4'h0;
  localparam logic [SEG_DATA_W-1:0] DATA_RESET = 128'h0;

  // buffer in front of the output stage
  localparam int FIFO_DEPTH = 8;

  // reset timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RST_MIN_NS = 5;
  localparam int RST_MIN_CYC = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_SYNC_STAGES = (RST_MIN_CYC < 2) ? 2 : RST_MIN_CYC;
endpackage

//--- logic/seg_word_fifo.sv
/*
  Small synchronous FIFO holding whole four-segment words between the packet source
  and the output stage. Width and depth are parameters; depth must be a power of two.
  Assumes push and pop sides run on the same clock and a reset already synchronised.
*/
`timescale 1ns/1ps
`default_nettype none

module seg_word_fifo #(
  parameter int WIDTH = rx_seg_pkg::WORD_W,
  parameter int DEPTH = rx_seg_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic ready_r;
  logic push;
  logic pop;

  assign push = in_valid && ready_r;
  assign pop = out_valid && out_ready;
  assign in_ready = ready_r;
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];

  // occupancy after this cycle's push and pop
  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + CNT_W'(1);
    end else if (pop && !push) begin
      count_nxt = count_r - CNT_W'(1);
    end
  end

  // storage has no reset; only words below count_r are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers, count and a registered ready so the source sees a clean flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      ready_r <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_r <= PTR_W'(wr_ptr_r + PTR_W'(1));
      end
      if (pop) begin
        rd_ptr_r <= PTR_W'(rd_ptr_r + PTR_W'(1));
      end
      count_r <= count_nxt;
      ready_r <= (count_nxt != CNT_FULL);
    end
  end

  a_full_refuses: assert property (@(posedge clk) disable iff (rst) // [RULE_11]
    (count_r == CNT_FULL) |-> !in_ready)
    else $error("fifo full but ready high");
  a_push_counts: assert property (@(posedge clk) disable iff (rst) // [RULE_11]
    (push && !pop) |=> (count_r == $past(count_r) + CNT_W'(1)))
    else $error("push did not raise occupancy");
  c_fifo_full: cover property (@(posedge clk) disable iff (rst) count_r == CNT_FULL);
endmodule

`default_nettype wire

//--- logic/rx_segment_output.sv
/*
  Receive-side segmented local bus output stage: takes four-segment words from the
  packet source, buffers them, and drives four qualified 128-bit segments to user logic.
  Assumes the source runs on clk and honours in_ready; user logic has no stall input.
*/
// Summary of operation
// RULE_01: four 128-bit segments, numbered 0 to 3, all driven on clk.
// RULE_02: segment data matters only while that segment's valid is high.
// RULE_03: valid qualifies first, last and bad; they read low when valid is low.
// RULE_04: first high with valid marks the segment holding a packet's first bytes.
// RULE_05: last high with valid marks the segment holding a packet's final bytes.
// RULE_06: bad high reports an erroneous packet; only meaningful with valid and last.
// RULE_07: bad low on a qualified final segment means the packet is error free.
// RULE_08: 4-bit empty count gives invalid bytes of a final segment.
// RULE_09: when valid and bad are high, empty count low three bits read zero.
// RULE_10: outputs change on rising clk; async high reset synchronised internally.
// RULE_11: user logic accepts every qualified segment each cycle; no back-pressure exists.
`timescale 1ns/1ps
`default_nettype none

module rx_segment_output #(
  parameter int FIFO_DEPTH = rx_seg_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_word_valid,
  output logic in_ready,
  input wire logic [rx_seg_pkg::SEG_COUNT*rx_seg_pkg::SEG_DATA_W-1:0] in_data,
  input wire logic [rx_seg_pkg::SEG_COUNT-1:0] in_valid,
  input wire logic [rx_seg_pkg::SEG_COUNT-1:0] in_first,
  input wire logic [rx_seg_pkg::SEG_COUNT-1:0] in_last,
  input wire logic [rx_seg_pkg::SEG_COUNT-1:0] in_bad,
  input wire logic [rx_seg_pkg::SEG_COUNT*rx_seg_pkg::SEG_EMPTY_W-1:0] in_empty,
  input wire logic deliver_en,
  output logic [rx_seg_pkg::SEG_DATA_W-1:0] rx_seg0_data,
  output logic [rx_seg_pkg::SEG_DATA_W-1:0] rx_seg1_data,
  output logic [rx_seg_pkg::SEG_DATA_W-1:0] rx_seg2_data,
  output logic [rx_seg_pkg::SEG_DATA_W-1:0] rx_seg3_data,
  output logic rx_seg0_valid,
  output logic rx_seg1_valid,
  output logic rx_seg2_valid,
  output logic rx_seg3_valid,
  output logic rx_seg0_first,
  output logic rx_seg1_first,
  output logic rx_seg2_first,
  output logic rx_seg3_first,
  output logic rx_seg0_last,
  output logic rx_seg1_last,
  output logic rx_seg2_last,
  output logic rx_seg3_last,
  output logic rx_seg0_bad,
  output logic rx_seg1_bad,
  output logic rx_seg2_bad,
  output logic rx_seg3_bad,
  output logic [rx_seg_pkg::SEG_EMPTY_W-1:0] rx_seg0_empty_bytes,
  output logic [rx_seg_pkg::SEG_EMPTY_W-1:0] rx_seg1_empty_bytes,
  output logic [rx_seg_pkg::SEG_EMPTY_W-1:0] rx_seg2_empty_bytes,
  output logic [rx_seg_pkg::SEG_EMPTY_W-1:0] rx_seg3_empty_bytes
);
  localparam int NSEG = rx_seg_pkg::SEG_COUNT;
  localparam int DW = rx_seg_pkg::SEG_DATA_W;
  localparam int EW = rx_seg_pkg::SEG_EMPTY_W;
  localparam int SW = rx_seg_pkg::SEG_W;
  localparam int WW = rx_seg_pkg::WORD_W;
  localparam int NSYNC = rx_seg_pkg::RST_SYNC_STAGES;

  // slice of one segment out of a buffered word
  function automatic logic [SW-1:0] seg_slice(input logic [WW-1:0] word, input int idx);
    seg_slice = word[idx*SW +: SW];
  endfunction

  // empty count as driven: quiet off a final segment, low bits cleared on error
  function automatic logic [EW-1:0] empty_out(input logic vld, input logic lst, input logic bd,
                                              input logic [EW-1:0] cnt);
    empty_out = rx_seg_pkg::EMPTY_RESET;
    if (vld && lst) begin
      empty_out = bd ? (cnt & rx_seg_pkg::EMPTY_BAD_KEEP) : cnt;
    end
  endfunction

  logic [NSYNC-1:0] rst_pipe_r;
  logic path_rst;
  logic [WW-1:0] in_word;
  logic [WW-1:0] head_word;
  logic head_valid;
  logic pop;
  logic err_pend_r;
  logic err_pend_nxt;
  logic [NSEG-1:0] bad_nxt;
  logic [DW-1:0] seg_data_r [NSEG];
  logic [NSEG-1:0] seg_valid_r;
  logic [NSEG-1:0] seg_first_r;
  logic [NSEG-1:0] seg_last_r;
  logic [NSEG-1:0] seg_bad_r;
  logic [EW-1:0] seg_empty_r [NSEG];
  logic [DW-1:0] head_seg_data [NSEG];
  logic [EW-1:0] head_seg_empty [NSEG];
  logic [NSEG-1:0] head_seg_valid;
  logic [NSEG-1:0] head_seg_first;
  logic [NSEG-1:0] head_seg_last;

  // reset synchroniser: asserts at once, releases NSYNC edges after rst falls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rst_pipe_r <= '1;
    end else begin
      rst_pipe_r <= {rst_pipe_r[NSYNC-2:0], 1'b0}; // [RULE_10]
    end
  end
  assign path_rst = rst_pipe_r[NSYNC-1];

  // pack the four incoming segments into one buffered word
  for (genvar g = 0; g < NSEG; g++) begin : g_pack
    assign in_word[g*SW + rx_seg_pkg::SEG_DATA_LSB +: DW] = in_data[g*DW +: DW];
    assign in_word[g*SW + rx_seg_pkg::SEG_EMPTY_LSB +: EW] = in_empty[g*EW +: EW];
    assign in_word[g*SW + rx_seg_pkg::SEG_VALID_BIT] = in_valid[g];
    assign in_word[g*SW + rx_seg_pkg::SEG_FIRST_BIT] = in_first[g];
    assign in_word[g*SW + rx_seg_pkg::SEG_LAST_BIT] = in_last[g];
    assign in_word[g*SW + rx_seg_pkg::SEG_BAD_BIT] = in_bad[g];
  end

  // buffer absorbs a source burst while delivery is held off
  seg_word_fifo #(
    .WIDTH(WW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(path_rst),
    .in_valid(in_word_valid),
    .in_ready(in_ready),
    .in_data(in_word),
    .out_valid(head_valid),
    .out_ready(deliver_en),
    .out_data(head_word)
  );

  // user side cannot stall, so only the internal enable gates a pop
  assign pop = head_valid && deliver_en; // [RULE_11]

  // head word split into per-segment fields once, shared by the output processes;
  // keeps the clocked processes free of blocking temporaries
  for (genvar g = 0; g < NSEG; g++) begin : g_head
    assign head_seg_data[g] = head_word[g*SW + rx_seg_pkg::SEG_DATA_LSB +: DW];
    assign head_seg_empty[g] = head_word[g*SW + rx_seg_pkg::SEG_EMPTY_LSB +: EW];
    assign head_seg_valid[g] = head_word[g*SW + rx_seg_pkg::SEG_VALID_BIT];
    assign head_seg_first[g] = head_word[g*SW + rx_seg_pkg::SEG_FIRST_BIT];
    assign head_seg_last[g] = head_word[g*SW + rx_seg_pkg::SEG_LAST_BIT];
  end

  // an error seen mid-packet is carried to the packet's final segment
  always_comb begin
    logic [SW-1:0] s;
    logic pend;
    s = '0;
    pend = err_pend_r;
    bad_nxt = '0;
    for (int i = 0; i < NSEG; i++) begin
      s = seg_slice(head_word, i);
      if (s[rx_seg_pkg::SEG_VALID_BIT]) begin
        if (s[rx_seg_pkg::SEG_FIRST_BIT]) begin
          pend = 1'b0;
        end
        pend = pend | s[rx_seg_pkg::SEG_BAD_BIT];
        if (s[rx_seg_pkg::SEG_LAST_BIT]) begin
          bad_nxt[i] = pend; // [RULE_06] [RULE_07]
          pend = 1'b0;
        end
      end
    end
    err_pend_nxt = pend;
  end

  // pending error across words
  always_ff @(posedge clk or posedge path_rst) begin
    if (path_rst) begin
      err_pend_r <= 1'b0;
    end else if (pop) begin
      err_pend_r <= err_pend_nxt;
    end
  end

  // qualified flags: nothing, valid included, goes high outside a popped word
  always_ff @(posedge clk or posedge path_rst) begin
    if (path_rst) begin
      seg_valid_r <= '0;
      seg_first_r <= '0;
      seg_last_r <= '0;
      seg_bad_r <= '0;
    end else begin
      for (int i = 0; i < NSEG; i++) begin
        seg_valid_r[i] <= pop && head_seg_valid[i]; // [RULE_01] [RULE_02]
        seg_first_r[i] <= pop && head_seg_valid[i] && head_seg_first[i]; // [RULE_03] [RULE_04]
        seg_last_r[i] <= pop && head_seg_valid[i] && head_seg_last[i]; // [RULE_03] [RULE_05]
        seg_bad_r[i] <= pop && bad_nxt[i]; // [RULE_06]
      end
    end
  end

  // data and empty counts; data is held when idle to save toggling
  always_ff @(posedge clk or posedge path_rst) begin
    if (path_rst) begin
      for (int i = 0; i < NSEG; i++) begin
        seg_data_r[i] <= rx_seg_pkg::DATA_RESET;
        seg_empty_r[i] <= rx_seg_pkg::EMPTY_RESET;
      end
    end else begin
      for (int i = 0; i < NSEG; i++) begin
        if (pop && head_seg_valid[i]) begin
          seg_data_r[i] <= head_seg_data[i]; // [RULE_02]
        end
        seg_empty_r[i] <= pop ? empty_out(head_seg_valid[i], head_seg_last[i], bad_nxt[i], head_seg_empty[i])
                              : rx_seg_pkg::EMPTY_RESET; // [RULE_08] [RULE_09]
      end
    end
  end

  // ports straight from the output flops
  assign rx_seg0_data = seg_data_r[0];
  assign rx_seg1_data = seg_data_r[1];
  assign rx_seg2_data = seg_data_r[2];
  assign rx_seg3_data = seg_data_r[3];
  assign rx_seg0_valid = seg_valid_r[0];
  assign rx_seg1_valid = seg_valid_r[1];
  assign rx_seg2_valid = seg_valid_r[2];
  assign rx_seg3_valid = seg_valid_r[3];
  assign rx_seg0_first = seg_first_r[0];
  assign rx_seg1_first = seg_first_r[1];
  assign rx_seg2_first = seg_first_r[2];
  assign rx_seg3_first = seg_first_r[3];
  assign rx_seg0_last = seg_last_r[0];
  assign rx_seg1_last = seg_last_r[1];
  assign rx_seg2_last = seg_last_r[2];
  assign rx_seg3_last = seg_last_r[3];
  assign rx_seg0_bad = seg_bad_r[0];
  assign rx_seg1_bad = seg_bad_r[1];
  assign rx_seg2_bad = seg_bad_r[2];
  assign rx_seg3_bad = seg_bad_r[3];
  assign rx_seg0_empty_bytes = seg_empty_r[0];
  assign rx_seg1_empty_bytes = seg_empty_r[1];
  assign rx_seg2_empty_bytes = seg_empty_r[2];
  assign rx_seg3_empty_bytes = seg_empty_r[3];

  // checks per segment on the driven outputs
  for (genvar g = 0; g < NSEG; g++) begin : g_chk
    a_first_qualified: assert property (@(posedge clk) disable iff (path_rst) // [RULE_04]
      seg_first_r[g] |-> seg_valid_r[g])
      else $error("first flag without valid");
    a_last_qualified: assert property (@(posedge clk) disable iff (path_rst) // [RULE_05]
      seg_last_r[g] |-> seg_valid_r[g])
      else $error("last flag without valid");
    a_bad_needs_end: assert property (@(posedge clk) disable iff (path_rst) // [RULE_06]
      seg_bad_r[g] |-> (seg_valid_r[g] && seg_last_r[g]))
      else $error("bad flag outside a final segment");
    a_empty_bad_zero: assert property (@(posedge clk) disable iff (path_rst) // [RULE_09]
      (seg_valid_r[g] && seg_bad_r[g]) |-> (seg_empty_r[g][2:0] == 3'h0))
      else $error("errored segment has nonzero low empty bits");
    a_empty_quiet: assert property (@(posedge clk) disable iff (path_rst) // [RULE_08]
      !(seg_valid_r[g] && seg_last_r[g]) |-> (seg_empty_r[g] == rx_seg_pkg::EMPTY_RESET))
      else $error("empty count off a final segment");
    a_flags_follow: assert property (@(posedge clk) disable iff (path_rst) // [RULE_03]
      pop |=> (seg_valid_r[g] == $past(head_word[g*SW + rx_seg_pkg::SEG_VALID_BIT])
               && seg_first_r[g] == $past(head_word[g*SW + rx_seg_pkg::SEG_VALID_BIT]
                                          && head_word[g*SW + rx_seg_pkg::SEG_FIRST_BIT])))
      else $error("segment flags do not follow the popped word");
    a_data_follows: assert property (@(posedge clk) disable iff (path_rst) // [RULE_01]
      (pop && head_word[g*SW + rx_seg_pkg::SEG_VALID_BIT])
        |=> (seg_data_r[g] == $past(head_word[g*SW +: DW])))
      else $error("segment data does not follow the popped word");
    a_last_follows: assert property (@(posedge clk) disable iff (path_rst) // [RULE_05]
      pop |=> (seg_last_r[g] == $past(head_seg_valid[g] && head_seg_last[g])))
      else $error("last flag does not follow the popped word");
    // an error on the final segment itself must show, whatever the carry logic does
    a_bad_reported: assert property (@(posedge clk) disable iff (path_rst) // [RULE_06]
      (pop && head_seg_valid[g] && head_seg_last[g] && head_word[g*SW + rx_seg_pkg::SEG_BAD_BIT])
        |=> seg_bad_r[g])
      else $error("error on a final segment not reported");
    a_empty_follows: assert property (@(posedge clk) disable iff (path_rst) // [RULE_08]
      (pop && head_seg_valid[g] && head_seg_last[g] && !bad_nxt[g])
        |=> (seg_empty_r[g] == $past(head_seg_empty[g])))
      else $error("empty count does not follow a clean final segment");
  end

  a_idle_quiet: assert property (@(posedge clk) disable iff (path_rst) // [RULE_02]
    !pop |=> (seg_valid_r == '0))
    else $error("valid raised without a popped word");
  a_good_end: assert property (@(posedge clk) disable iff (path_rst) // [RULE_07]
    (seg_valid_r[0] && seg_last_r[0] && !seg_bad_r[0])
      |-> ((!$past(err_pend_r) || $past(head_word[rx_seg_pkg::SEG_FIRST_BIT]))
           && !$past(head_word[rx_seg_pkg::SEG_BAD_BIT])))
    else $error("clean end reported for an errored packet");
  a_reset_release: assert property (@(posedge clk) // [RULE_10]
    $fell(rst) |-> path_rst [*2] ##1 !path_rst)
    else $error("internal reset release not two edges after rst");
  // reset in mid-run must silence the user side at once, not at the next word
  a_reset_quiet: assert property (@(posedge clk) // [RULE_10]
    path_rst |-> (seg_valid_r == '0 && seg_bad_r == '0 && !in_ready))
    else $error("outputs active while the path is held in reset");

  c_back_to_back: cover property (@(posedge clk) disable iff (path_rst) pop [*3]);
  c_error_end: cover property (@(posedge clk) disable iff (path_rst) seg_bad_r != '0);
  c_stall_refill: cover property (@(posedge clk) disable iff (path_rst)
    (head_valid && !deliver_en) [*4] ##1 pop);
  c_split_packet: cover property (@(posedge clk) disable iff (path_rst)
    seg_first_r[3] ##1 seg_last_r[0]);
endmodule

`default_nettype wire

//--- tb/rx_user_sink.sv
/*
  User-side sink model: takes every qualified segment each cycle and logs each word.
  Assumes the outputs change on rising clk.
*/
`timescale 1ns/1ps
`default_nettype none

module rx_user_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic [511:0] data,
  input wire logic [3:0] valid,
  input wire logic [3:0] first,
  input wire logic [3:0] last,
  input wire logic [3:0] bad,
  input wire logic [15:0] empty
);
  logic [511:0] data_q[$];
  logic [31:0] flag_q[$];

  // no stall input exists, so a word is logged the cycle it shows
  always @(posedge clk) begin
    if (!rst && valid != 4'h0) begin
      data_q.push_back(data);
      flag_q.push_back({empty, bad, last, first, valid});
    end
  end
endmodule
`default_nettype wire

//--- tb/rx_segment_output_tb_top.sv
/*
  Bench for the segmented receive output stage: scenario tasks push source words and
  judge what the sink logs. Assumes the package and the sink model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin errors++; \
  $display("CHECK FAILED %s exp=%0h got=%0h", nm, ex, got); end end

module rx_segment_output_tb_top;
  int errors = 0;
  int compares = 0;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic in_word_valid = 1'b0;
  logic deliver_en = 1'b1;
  logic [511:0] in_data = 512'h0;
  logic [3:0] in_valid = 4'h0, in_first = 4'h0, in_last = 4'h0, in_bad = 4'h0;
  logic [15:0] in_empty = 16'h0;
  wire in_ready;
  wire [127:0] d0, d1, d2, d3;
  wire [3:0] v, f, l, b, e0, e1, e2, e3;

  // 250 MHz clock
  always #2 clk = ~clk;

  rx_segment_output DUT (.clk(clk), .rst(rst), .in_word_valid(in_word_valid), .in_ready(in_ready),
    .in_data(in_data), .in_valid(in_valid), .in_first(in_first), .in_last(in_last), .in_bad(in_bad),
    .in_empty(in_empty), .deliver_en(deliver_en),
    .rx_seg0_data(d0), .rx_seg1_data(d1), .rx_seg2_data(d2), .rx_seg3_data(d3),
    .rx_seg0_valid(v[0]), .rx_seg1_valid(v[1]), .rx_seg2_valid(v[2]), .rx_seg3_valid(v[3]),
    .rx_seg0_first(f[0]), .rx_seg1_first(f[1]), .rx_seg2_first(f[2]), .rx_seg3_first(f[3]),
    .rx_seg0_last(l[0]), .rx_seg1_last(l[1]), .rx_seg2_last(l[2]), .rx_seg3_last(l[3]),
    .rx_seg0_bad(b[0]), .rx_seg1_bad(b[1]), .rx_seg2_bad(b[2]), .rx_seg3_bad(b[3]),
    .rx_seg0_empty_bytes(e0), .rx_seg1_empty_bytes(e1), .rx_seg2_empty_bytes(e2),
    .rx_seg3_empty_bytes(e3));

  rx_user_sink sink (.clk(clk), .rst(rst), .data({d3, d2, d1, d0}), .valid(v), .first(f),
    .last(l), .bad(b), .empty({e3, e2, e1, e0}));

  // distinct lanes per word so a swapped segment shows
  function automatic logic [511:0] dat(input int n);
    logic [511:0] r;
    for (int i = 0; i < 4; i++) begin
      r[i*128 +: 128] = {4{32'(n * 4 + i)}};
    end
    return r;
  endfunction

  // offer one word and hold it until the buffer takes it
  task automatic push(input int n, input logic [3:0] pv, pf, pl, pb, input logic [15:0] pe);
    int k;
    in_word_valid <= 1'b1;
    in_data <= dat(n);
    in_valid <= pv;
    in_first <= pf;
    in_last <= pl;
    in_bad <= pb;
    in_empty <= pe;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (in_ready !== 1'b1 && k < 40);
    `CHK("word taken", 1'b1, in_ready)
  endtask

  task automatic idle();
    in_word_valid <= 1'b0;
    @(posedge clk);
  endtask

  // next logged word; data judged on qualified lanes only
  task automatic expect_word(input int n, input logic [3:0] xv, xf, xl, xb, input logic [15:0] xe);
    int k;
    logic [511:0] m;
    logic [511:0] gd;
    logic [31:0] g;
    k = 0;
    while (sink.flag_q.size() == 0 && k < 40) begin
      @(posedge clk);
      k++;
    end
    `CHK("word logged", 1'b1, sink.flag_q.size() != 0)
    if (sink.flag_q.size() != 0) begin
      g = sink.flag_q.pop_front();
      gd = sink.data_q.pop_front();
      for (int i = 0; i < 4; i++) begin
        m[i*128 +: 128] = {128{xv[i]}};
      end
      `CHK("data", dat(n) & m, gd & m)
      `CHK("valid", xv, g[3:0])
      `CHK("first", xf, g[7:4])
      `CHK("last", xl, g[11:8])
      `CHK("bad", xb, g[15:12])
      `CHK("empty", xe, g[31:16])
    end
  endtask

  // outputs and ready held low through reset
  task automatic t_reset();
    repeat (5) @(posedge clk);
    `CHK("ready in reset", 1'b0, in_ready)
    `CHK("flags in reset", 16'h0, {v, f, l, b})
    `CHK("empty in reset", 16'h0, {e3, e2, e1, e0})
    `CHK("data in reset", 512'h0, {d3, d2, d1, d0})
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    $display("reset test done");
  endtask

  // bad mid-word carried to the end, low empty bits cleared, top bit kept
  task automatic t_walk();
    push(1, 4'h7, 4'h1, 4'h4, 4'h2, 16'h0D00);
    idle();
    expect_word(1, 4'h7, 4'h1, 4'h4, 4'h4, 16'h0800);
    push(2, 4'hF, 4'h1, 4'h8, 4'h0, 16'h5333);
    idle();
    expect_word(2, 4'hF, 4'h1, 4'h8, 4'h0, 16'h5000);
    $display("walk test done");
  endtask

  // flags on unqualified lanes must not leak out
  task automatic t_mask();
    push(3, 4'h5, 4'hF, 4'hF, 4'hF, 16'hFFFF);
    idle();
    expect_word(3, 4'h5, 4'h5, 4'h5, 4'h5, 16'h0808);
    $display("mask test done");
  endtask

  // packets over four back-to-back words; error carried to the next word's end,
  // a start on segment 3 ends on segment 0 of the next word
  task automatic t_span();
    push(4, 4'hF, 4'h1, 4'h0, 4'h1, 16'h0);
    push(5, 4'h1, 4'h0, 4'h1, 4'h0, 16'h0002);
    push(6, 4'h9, 4'h9, 4'h1, 4'h0, 16'h0002);
    push(7, 4'h1, 4'h0, 4'h1, 4'h0, 16'h000F);
    idle();
    expect_word(4, 4'hF, 4'h1, 4'h0, 4'h0, 16'h0);
    expect_word(5, 4'h1, 4'h0, 4'h1, 4'h1, 16'h0);
    expect_word(6, 4'h9, 4'h9, 4'h1, 4'h0, 16'h0002);
    expect_word(7, 4'h1, 4'h0, 4'h1, 4'h0, 16'h000F);
    $display("span test done");
  endtask

  // stall draining until the buffer refuses, then drain in order
  task automatic t_fill();
    deliver_en <= 1'b0;
    for (int n = 10; n < 18; n++) begin
      push(n, 4'hF, 4'h0, 4'h0, 4'h0, 16'h0);
    end
    in_data <= dat(18);
    repeat (3) begin
      @(posedge clk);
      `CHK("ready when full", 1'b0, in_ready)
    end
    `CHK("stalled", 0, sink.flag_q.size())
    deliver_en <= 1'b1;
    push(18, 4'hF, 4'h0, 4'h0, 4'h0, 16'h0);
    idle();
    for (int n = 10; n < 19; n++) begin
      expect_word(n, 4'hF, 4'h0, 4'h0, 4'h0, 16'h0);
    end
    $display("fill test done");
  endtask

  // reset in mid-run: a pending error and a buffered word are both dropped
  task automatic t_rerun();
    push(20, 4'hF, 4'h1, 4'h0, 4'h1, 16'h0);
    idle();
    expect_word(20, 4'hF, 4'h1, 4'h0, 4'h0, 16'h0);
    deliver_en <= 1'b0;
    push(21, 4'hF, 4'h1, 4'h1, 4'h0, 16'h0);
    idle();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("ready in mid reset", 1'b0, in_ready)
    `CHK("flags in mid reset", 16'h0, {v, f, l, b})
    rst <= 1'b0;
    deliver_en <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("flushed by reset", 0, sink.flag_q.size())
    push(22, 4'h1, 4'h0, 4'h1, 4'h0, 16'h0003);
    idle();
    expect_word(22, 4'h1, 4'h0, 4'h1, 4'h0, 16'h0003);
    $display("mid-run reset test done");
  endtask

  task automatic report_and_stop();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // scenario sequence
  initial begin
    t_reset();
    t_walk();
    t_mask();
    t_span();
    t_fill();
    t_rerun();
    repeat (5) @(posedge clk);
    `CHK("no extra words", 0, sink.flag_q.size())
    report_and_stop();
  end

  // watchdog far beyond the hundred or so cycles the scenarios need
  initial begin
    #20000;
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
